// ===== cpf_pkg.sv
// package: register map, field positions and reset values for the polarity and fault status block
package cpf_pkg;
	localparam int CPF_NUM_CH = 8;
	localparam int CPF_NUM_FLT = 4;
	localparam logic [7:0] CPF_ADDR_POLARITY = 8'h70;
	localparam logic [7:0] CPF_ADDR_FAULT_STATUS = 8'h74;
	localparam logic [7:0] CPF_ADDR_FAULT_CTRL = 8'h78;
	localparam logic [7:0] CPF_ADDR_IRQ_STATUS = 8'h7C;
	localparam logic [7:0] CPF_ADDR_IRQ_MASK = 8'h80;
	localparam logic [7:0] CPF_POLARITY_RESET = 8'h00;
	localparam int CPF_FS_COMBINED = 7;
	localparam int CPF_FS_WRITE_PROTECT_ENABLE = 6;
	localparam int CPF_FS_INPUTS_OR = 5;
	localparam int CPF_FC_FAULT_EN = 0;
	localparam int CPF_FC_WRITE_PROTECT_DISABLE = 1;
	localparam int CPF_FC_INPUT_EN = 4;
	localparam int CPF_IRQ_FAULT = 0;
	localparam int CPF_IRQ_CLEARED = 1;
	localparam logic [1:0] CPF_IRQ_RESET = 2'h0;
endpackage : cpf_pkg

// ===== cpf_top.sv
// channel polarity, fault safe state and fault status registers behind a classic wishbone slave
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/10ps
module cpf_top #(
	parameter int NUM_CH = cpf_pkg::CPF_NUM_CH,
	parameter int NUM_FLT = cpf_pkg::CPF_NUM_FLT
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [NUM_CH-1:0] ch_wave_i,
	input wire logic [NUM_FLT-1:0] fault_pin_i,
	output logic [NUM_CH-1:0] ch_pin_o,
	output logic irq_o
);
	import cpf_pkg::*;

	logic [NUM_CH-1:0] channel_polarity_bit;
	logic [NUM_FLT-1:0] per_input_fault_flag;
	logic [NUM_FLT-1:0] input_enable;
	logic fault_enable;
	logic write_protect_disable;
	logic [NUM_FLT-1:0] flt_meta;
	logic [NUM_FLT-1:0] flt_sync;
	logic [NUM_FLT-1:0] armed;
	logic comb_armed;
	logic write_protect_enable_seen;
	logic [1:0] irq_status;
	logic [1:0] irq_mask;
	logic combined_fault_flag;
	logic fault_inputs_or;
	logic [NUM_FLT-1:0] fault_now;
	logic [NUM_FLT-1:0] next_flag;
	logic req;
	logic wr;
	logic rd;
	logic wr_lane0;
	logic rd_status;
	logic wr_status;
	logic [31:0] rd_data;
	logic [1:0] irq_event;

	assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr = req & wb_we_i;
	assign rd = req & ~wb_we_i;
	assign wr_lane0 = wr & wb_sel_i[0];
	assign rd_status = rd & (wb_adr_i == CPF_ADDR_FAULT_STATUS);
	assign wr_status = wr_lane0 & (wb_adr_i == CPF_ADDR_FAULT_STATUS);

	// two-stage synchroniser; only flt_sync feeds logic
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			flt_meta <= '0;
			flt_sync <= '0;
		end else begin
			flt_meta <= fault_pin_i;
			flt_sync <= flt_meta;
		end
	end

	assign fault_now = flt_sync & input_enable & {NUM_FLT{fault_enable}};
	assign fault_inputs_or = |fault_now;
	assign combined_fault_flag = |per_input_fault_flag;

	// a flag is armed by a status read seeing it set; a new fault disarms it
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			armed <= '0;
			comb_armed <= 1'b0;
		end else begin
			for (int j = 0; j < NUM_FLT; j++) begin
				if (fault_now[j]) begin
					armed[j] <= 1'b0;
				end else if (rd_status && per_input_fault_flag[j]) begin
					armed[j] <= 1'b1;
				end else if (wr_status) begin
					armed[j] <= 1'b0;
				end
			end
			if (fault_inputs_or) begin
				comb_armed <= 1'b0;
			end else if (rd_status && combined_fault_flag) begin
				comb_armed <= 1'b1;
			end else if (wr_status) begin
				comb_armed <= 1'b0;
			end
		end
	end

	always_comb begin
		next_flag = per_input_fault_flag;
		for (int j = 0; j < NUM_FLT; j++) begin
			// clearing the combined flag clears every per-input flag too
			if (wr_status && !wb_dat_i[CPF_FS_COMBINED] && comb_armed && !fault_inputs_or) begin
				next_flag[j] = 1'b0;
			end
			if (wr_status && !wb_dat_i[j] && armed[j] && !fault_now[j]) begin
				next_flag[j] = 1'b0;
			end
			// set wins over a clear landing in the same cycle; writing 1 never sets
			if (fault_now[j]) begin
				next_flag[j] = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			per_input_fault_flag <= '0;
		end else begin
			per_input_fault_flag <= next_flag;
		end
	end

	// write protect: disable only lands after enable was read as 1
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			write_protect_disable <= 1'b0;
			write_protect_enable_seen <= 1'b0;
		end else begin
			if (rd_status && !write_protect_disable) begin
				write_protect_enable_seen <= 1'b1;
			end else if (wr_lane0 && wb_adr_i == CPF_ADDR_FAULT_CTRL) begin
				write_protect_enable_seen <= 1'b0;
			end
			if (wr_status && wb_dat_i[CPF_FS_WRITE_PROTECT_ENABLE]) begin
				write_protect_disable <= 1'b0;
			end else if (wr_lane0 && wb_adr_i == CPF_ADDR_FAULT_CTRL && wb_dat_i[CPF_FC_WRITE_PROTECT_DISABLE] && write_protect_enable_seen) begin
				write_protect_disable <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fault_enable <= 1'b0;
			input_enable <= '0;
		end else if (wr_lane0 && wb_adr_i == CPF_ADDR_FAULT_CTRL) begin
			fault_enable <= wb_dat_i[CPF_FC_FAULT_EN];
			input_enable <= wb_dat_i[CPF_FC_INPUT_EN +: NUM_FLT];
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			channel_polarity_bit <= CPF_POLARITY_RESET[NUM_CH-1:0];
		end else if (wr_lane0 && wb_adr_i == CPF_ADDR_POLARITY && write_protect_disable) begin
			channel_polarity_bit <= wb_dat_i[NUM_CH-1:0];
		end
	end

	// output stage: safe level under fault, else waveform through polarity
	genvar c;
	generate
		for (c = 0; c < NUM_CH; c++) begin : g_ch
			always_ff @(posedge clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					ch_pin_o[c] <= 1'b0;
				end else if (fault_enable && combined_fault_flag) begin
					ch_pin_o[c] <= channel_polarity_bit[c];
				end else begin
					ch_pin_o[c] <= ch_wave_i[c] ^ channel_polarity_bit[c];
				end
			end
		end
	endgenerate

	// interrupt events: fault flag rising, and combined flag cleared
	assign irq_event[CPF_IRQ_FAULT] = |(fault_now & ~per_input_fault_flag);
	assign irq_event[CPF_IRQ_CLEARED] = combined_fault_flag & ~(|next_flag);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_status <= CPF_IRQ_RESET;
			irq_mask <= CPF_IRQ_RESET;
			irq_o <= 1'b0;
		end else begin
			for (int k = 0; k < 2; k++) begin
				if (irq_event[k]) begin
					irq_status[k] <= 1'b1;
				end else if (wr_lane0 && wb_adr_i == CPF_ADDR_IRQ_STATUS && wb_dat_i[k]) begin
					irq_status[k] <= 1'b0;
				end
			end
			if (wr_lane0 && wb_adr_i == CPF_ADDR_IRQ_MASK) begin
				irq_mask <= wb_dat_i[1:0];
			end
			irq_o <= |(irq_status & irq_mask);
		end
	end

	always_comb begin
		rd_data = 32'h0000_0000;
		unique case (wb_adr_i)
			CPF_ADDR_POLARITY: rd_data[NUM_CH-1:0] = channel_polarity_bit;
			CPF_ADDR_FAULT_STATUS: begin
				rd_data[CPF_FS_COMBINED] = combined_fault_flag;
				rd_data[CPF_FS_WRITE_PROTECT_ENABLE] = ~write_protect_disable;
				rd_data[CPF_FS_INPUTS_OR] = fault_inputs_or;
				rd_data[NUM_FLT-1:0] = per_input_fault_flag;
			end
			CPF_ADDR_FAULT_CTRL: begin
				rd_data[CPF_FC_FAULT_EN] = fault_enable;
				rd_data[CPF_FC_WRITE_PROTECT_DISABLE] = write_protect_disable;
				rd_data[CPF_FC_INPUT_EN +: NUM_FLT] = input_enable;
			end
			CPF_ADDR_IRQ_STATUS: rd_data[1:0] = irq_status;
			CPF_ADDR_IRQ_MASK: rd_data[1:0] = irq_mask;
			default: rd_data = 32'h0000_0000;
		endcase
	end

	// every access, mapped or not, acks one cycle after it is seen; unmapped reads zero
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= req;
			if (rd) begin
				wb_dat_o <= rd_data;
			end
		end
	end
endmodule : cpf_top

// ===== cpf_monitor.sv
// checker for bus handshake, read fields and pin behaviour of cpf_top
`timescale 1ns/10ps
module cpf_monitor #(
	parameter int NUM_CH = 8,
	parameter int NUM_FLT = 4
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic [NUM_CH-1:0] ch_wave_i,
	input wire logic [NUM_FLT-1:0] fault_pin_i,
	input wire logic [NUM_CH-1:0] ch_pin_o,
	input wire logic irq_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_rd(a);
		wb_ack_o && !wb_we_i && wb_adr_i == a;
	endsequence
	// sync delay plus safe-state latch settles inside five quiet cycles
	sequence s_quiet;
		(!wb_cyc_i && fault_pin_i == '0 && $stable(ch_wave_i)) [*5];
	endsequence
	a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing after request");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack without request");
	a_fs_reserved: assert property (s_rd(8'h74) |-> wb_dat_o[31:8] == 0 && !wb_dat_o[4])
		else $error("fault status reserved bits set");
	a_flag_or: assert property (s_rd(8'h74) |-> wb_dat_o[7] == |wb_dat_o[3:0])
		else $error("combined flag differs from per-input OR");
	a_pol_reserved: assert property (s_rd(8'h70) |-> wb_dat_o[31:8] == 0)
		else $error("polarity upper bits set");
	a_unmapped_zero: assert property (wb_ack_o && !wb_we_i
		&& !(wb_adr_i inside {8'h70, 8'h74, 8'h78, 8'h7C, 8'h80}) |-> wb_dat_o == 0)
		else $error("unmapped read not zero");
	a_pin_quiet: assert property (s_quiet |=> $stable(ch_pin_o))
		else $error("pin moved with quiet inputs");
endmodule : cpf_monitor
bind cpf_top cpf_monitor #(.NUM_CH(NUM_CH), .NUM_FLT(NUM_FLT)) u_mon (.clk_i(clk_i), .rst_n_i(rst_n_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ch_wave_i(ch_wave_i),
	.fault_pin_i(fault_pin_i), .ch_pin_o(ch_pin_o), .irq_o(irq_o));

// ===== test_cpf_top.sv
// self-checking bench for the polarity and fault status block
`timescale 1ns/10ps
module test_cpf_top;
	logic clk, rst_n, cyc, stb, we, ack, irq;
	logic [7:0] adr, wave, pin, p, w8;
	logic [3:0] sel, flt;
	logic [31:0] dat, rdat;
	logic [31:0] eq[$], mq[$];
	int bad_count = 0;
	int samples_checked = 0;
	cpf_top DUT (.clk_i(clk), .rst_n_i(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.ch_wave_i(wave), .fault_pin_i(flt), .ch_pin_o(pin), .irq_o(irq));
	initial begin
		clk = 0;
		forever #2 clk = ~clk;
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			bad_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] e = 32'h0, input logic [31:0] m = 32'hFFFFFFFF);
		if (!w) begin
			eq.push_back(e);
			mq.push_back(m);
		end
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		dat <= d;
		do @(posedge clk); while (ack !== 1'b1);
		cyc <= 0;
		stb <= 0;
		@(posedge clk);
	endtask : wb
	task automatic end_sim;
		$display("checks=%0d errors=%0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim
	// read results are matched in order against the driver's notes
	always @(posedge clk) begin
		if (ack === 1'b1 && we === 1'b0) begin
			chk(rdat & mq[0], eq[0] & mq[0]);
			void'(eq.pop_front());
			void'(mq.pop_front());
		end
	end
	initial begin
		#40000;
		bad_count++;
		end_sim();
	end
	initial begin
		void'($urandom(36271));
		{rst_n, cyc, stb, we, adr, dat, wave, flt} <= '0;
		sel <= 4'hF;
		repeat (12) @(posedge clk);
		rst_n <= 1;
		@(posedge clk);
		wb(0, 8'h70, 0, 0);
		wb(0, 8'h90, 0, 0);
		p = 8'($urandom);
		wb(1, 8'h70, {24'h0, p});
		wb(0, 8'h70, 0, 0);
		wb(0, 8'h74, 0, 32'h40);
		wb(1, 8'h78, 32'hF3);
		wb(1, 8'h70, {24'h0, p});
		wb(0, 8'h70, 0, {24'h0, p});
		wb(0, 8'h74, 0, 0);
		repeat (4) begin
			w8 = 8'($urandom);
			wave <= w8;
			repeat (2) @(posedge clk);
			chk(32'(pin), 32'(w8 ^ p));
		end
		wb(1, 8'h80, 1);
		flt <= 4'h4;
		repeat (6) @(posedge clk);
		chk(32'(pin), 32'(p));
		chk(32'(irq), 1);
		wb(0, 8'h74, 0, 32'hA4);
		wb(1, 8'h74, 32'h80);
		wb(0, 8'h74, 0, 32'hA4);
		wb(1, 8'h74, 0);
		wb(0, 8'h74, 0, 32'hA4);
		flt <= 0;
		repeat (4) @(posedge clk);
		wb(0, 8'h74, 0, 32'h84);
		flt <= 4'h2;
		repeat (4) @(posedge clk);
		flt <= 0;
		repeat (4) @(posedge clk);
		wb(1, 8'h74, 0);
		wb(0, 8'h74, 0, 32'h80, 32'h80);
		wb(1, 8'h74, 0);
		wb(0, 8'h74, 0, 0);
		flt <= 4'h1;
		repeat (6) @(posedge clk);
		flt <= 0;
		repeat (4) @(posedge clk);
		wb(0, 8'h74, 0, 32'h81);
		wb(1, 8'h74, 32'h80);
		wb(0, 8'h74, 0, 0);
		wb(1, 8'h80, 0);
		repeat (2) @(posedge clk);
		chk(32'(irq), 0);
		wb(1, 8'h80, 1);
		wb(1, 8'h7C, 3);
		repeat (2) @(posedge clk);
		chk(32'(irq), 0);
		wb(0, 8'h7C, 0, 0);
		wb(1, 8'h74, 32'h40);
		wb(1, 8'h70, {24'h0, ~p});
		wb(0, 8'h70, 0, {24'h0, p});
		repeat (3) @(posedge clk);
		end_sim();
	end
endmodule : test_cpf_top
